// >>> logic/conv_control.sv
`timescale 1ns/1ps

module conv_control
    import conv_pkg::*;
#(
    parameter logic [7:0] CONV_LEN = 8'(conv_pkg::CONV_CYCLES)
)
(
    // clock, reset, enable
    input  wire logic                         mclk_i,
    input  wire logic                         reset_i,
    input  wire logic                         ce_i,
    // conversion control
    input  wire logic                         conversion_start_n_i,
    input  wire logic                         bipolar_i,
    input  wire logic [conv_pkg::RESULT_W-1:0] sample_i,
    // read control
    input  wire logic                         chip_select_n_i,
    input  wire logic                         read_n_i,
    // status and result
    output logic                              busy_n_o,
    output logic                              hold_o,
    output logic      [conv_pkg::RESULT_W-1:0] result_bus_o,
    output logic                              result_bus_oe_o
);
    import conv_pkg::*;

    conv_state_t         state_reg;
    logic                start_n_prev_reg;
    logic [RESULT_W-1:0] latch_reg;
    logic [RESULT_W-1:0] coded;
    logic                conv_done;
    logic                start_fall;
    logic                start_rise;
    logic [CNT_W-1:0]    conv_age_reg;

    // ==========================================================
    // edge detection on conversion start (input is synchronous)
    // ==========================================================
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            start_n_prev_reg <= 1'b1;
        else if (ce_i)
            start_n_prev_reg <= conversion_start_n_i;
    end

    assign start_fall = start_n_prev_reg && !conversion_start_n_i;
    assign start_rise = !start_n_prev_reg && conversion_start_n_i;

    // ==========================================================
    // sub-blocks
    // ==========================================================
    conv_timer u_timer
    (
        .mclk_i   (mclk_i),
        .reset_i  (reset_i),
        .ce_i     (ce_i),
        .load_i   (start_rise && (state_reg == ST_HOLD)),
        .length_i (CONV_LEN),
        .done_o   (conv_done)
    );

    result_coder u_coder
    (
        .sample_i  (sample_i),
        .bipolar_i (bipolar_i),
        .code_o    (coded)
    );

    // ==========================================================
    // sequencer: track, hold, convert
    // ==========================================================
    // a start edge during conversion is ignored; host must not send one
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            state_reg <= ST_TRACK;
        else if (ce_i)
        begin
            unique case (state_reg)
                ST_TRACK:
                    if (start_fall)
                        state_reg <= ST_HOLD;
                ST_HOLD:
                    if (start_rise)
                        state_reg <= ST_CONV;
                ST_CONV:
                    if (conv_done)
                        state_reg <= ST_TRACK;
                default:
                    state_reg <= ST_TRACK;
            endcase
        end
    end

    // ==========================================================
    // sampler hold output
    // ==========================================================
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            hold_o <= 1'b0;
        else if (ce_i)
        begin
            if (state_reg == ST_TRACK && start_fall)
                hold_o <= 1'b1;
            else if (state_reg == ST_CONV && conv_done)
                hold_o <= 1'b0;
        end
    end

    // ==========================================================
    // busy output
    // ==========================================================
    // busy falls with conversion start, rises one cycle after the bus is back
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            busy_n_o <= 1'b1;
        else if (ce_i)
        begin
            if (state_reg == ST_HOLD && start_rise)
                busy_n_o <= 1'b0;
            else if (state_reg == ST_TRACK && !busy_n_o)
                busy_n_o <= 1'b1;
        end
    end

    // ==========================================================
    // output latch, captured from the held sample
    // ==========================================================
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            latch_reg <= CODE_ZERO;
        else if (ce_i && state_reg == ST_CONV && conv_done)
            latch_reg <= coded;
    end

    // ==========================================================
    // three-state bus drive
    // ==========================================================
    // bus comes up the cycle conversion ends, busy follows one cycle later
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            result_bus_o    <= CODE_ZERO;
            result_bus_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            result_bus_o <= (state_reg == ST_CONV && conv_done) ? coded : latch_reg;
            if ((state_reg == ST_HOLD && start_rise) || (state_reg == ST_CONV && !conv_done))
                result_bus_oe_o <= 1'b0;
            else
                result_bus_oe_o <= !chip_select_n_i && !read_n_i;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    // cycles spent converting, kept only for the length checks
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            conv_age_reg <= CNT_ZERO;
        else if (ce_i)
        begin
            if (state_reg == ST_HOLD && start_rise)
                conv_age_reg <= CNT_ONE;
            else if (state_reg == ST_CONV)
                conv_age_reg <= conv_age_reg + CNT_ONE;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence start_pulse_s;
        ce_i && state_reg == ST_HOLD && start_rise;
    endsequence

    sequence conv_end_s;
        ce_i && state_reg == ST_CONV && conv_done;
    endsequence

    sequence read_req_s;
        !chip_select_n_i && !read_n_i;
    endsequence

    hold_on_fall_a: assert property (
        ce_i && state_reg == ST_TRACK && start_fall |=> hold_o)
        else $error("hold not entered on start falling edge");

    no_busy_in_hold_a: assert property (
        state_reg == ST_HOLD |-> busy_n_o)
        else $error("busy low before start rising edge");

    busy_on_start_a: assert property (
        start_pulse_s |=> !busy_n_o)
        else $error("busy not low after start rising edge");

    track_after_end_a: assert property (
        conv_end_s |=> !hold_o && state_reg == ST_TRACK)
        else $error("sampler not back in track after conversion");

    bus_gate_a: assert property (
        result_bus_oe_o |-> !$past(chip_select_n_i) && !$past(read_n_i))
        else $error("bus driven without select and read");

    bus_off_conv_a: assert property (
        !busy_n_o && state_reg == ST_CONV |-> !result_bus_oe_o)
        else $error("bus driven during conversion");

    bus_before_busy_a: assert property (
        $rose(busy_n_o) && !$past(chip_select_n_i, 2) && !$past(read_n_i, 2)
            |-> $past(result_bus_oe_o))
        else $error("bus not active before busy rose");

    conv_length_a: assert property (
        conv_end_s |-> conv_age_reg == CONV_LEN)
        else $error("conversion length differs from setting");

    bipolar_code_a: assert property (
        conv_end_s ##0 bipolar_i && sample_i == CODE_ZERO |=> latch_reg == CODE_MID_HIGH)
        else $error("bipolar zero not at midscale");

    // sequencer and sampler
    hold_in_conv_a: assert property (
        state_reg == ST_CONV |-> hold_o)
        else $error("sampler not holding during conversion");

    hold_idle_a: assert property (
        state_reg == ST_TRACK |-> !hold_o)
        else $error("sampler holding while idle");

    // busy, conversion length and result latch
    busy_low_conv_a: assert property (
        state_reg == ST_CONV |-> !busy_n_o)
        else $error("busy high during conversion");

    busy_idle_a: assert property (
        $past(ce_i) && $past(state_reg) == ST_TRACK |-> busy_n_o)
        else $error("busy low while idle");

    conv_no_overrun_a: assert property (
        ce_i && state_reg == ST_CONV && conv_age_reg == CONV_LEN |-> conv_done)
        else $error("conversion ran past its length");

    latch_steady_a: assert property (
        ce_i && !(state_reg == ST_CONV && conv_done) |=> $stable(latch_reg))
        else $error("result latch changed outside conversion end");

    // bus drive
    bus_off_start_a: assert property (
        start_pulse_s |=> !result_bus_oe_o)
        else $error("bus still driven after conversion start");

    bus_on_end_a: assert property (
        conv_end_s ##0 read_req_s |=> result_bus_oe_o)
        else $error("bus not driven again after conversion");

    bus_stays_off_a: assert property (
        ce_i && state_reg == ST_CONV && !conv_done |=> !result_bus_oe_o)
        else $error("bus enabled inside conversion");

    bus_release_a: assert property (
        ce_i && (chip_select_n_i || read_n_i) |=> !result_bus_oe_o)
        else $error("bus driven after select or read went high");

    result_on_end_a: assert property (
        conv_end_s |=> result_bus_o == latch_reg && !busy_n_o)
        else $error("result not on bus while busy still low");

    bus_data_a: assert property (
        ce_i && state_reg == ST_TRACK |=> result_bus_o == latch_reg)
        else $error("bus does not carry the held result");

    // result coding
    bipolar_sign_a: assert property (
        conv_end_s ##0 bipolar_i |-> (coded ^ sample_i) == SIGN_FLIP)
        else $error("bipolar code is not offset binary");

    unipolar_code_a: assert property (
        conv_end_s ##0 !bipolar_i |-> coded == sample_i)
        else $error("unipolar code is not natural binary");

endmodule // conv_control

// >>> logic/conv_pkg.sv
package conv_pkg;

    // ==========================================================
    // result format
    // ==========================================================
    localparam int          RESULT_W      = 12;
    localparam logic [11:0] CODE_ZERO     = 12'h000;
    localparam logic [11:0] CODE_MID_LOW  = 12'h7ff;   // just below midscale
    localparam logic [11:0] CODE_MID_HIGH = 12'h800;   // just above midscale
    localparam logic [11:0] CODE_TOP      = 12'hfff;   // highest code
    localparam logic [11:0] SIGN_FLIP     = 12'h800;   // offset binary msb

    // ==========================================================
    // timing
    // ==========================================================
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          CONV_TIME_NS  = 1000;
    localparam int          CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W         = 8;
    localparam logic [7:0]  CNT_ZERO      = 8'h00;
    localparam logic [7:0]  CNT_ONE       = 8'h01;

    // ==========================================================
    // sequencer states
    // ==========================================================
    typedef enum logic [2:0]
    {
        ST_TRACK = 3'b001,
        ST_HOLD  = 3'b010,
        ST_CONV  = 3'b100
    } conv_state_t;

endpackage

// >>> logic/conv_timer.sv
`timescale 1ns/1ps

module conv_timer
    import conv_pkg::*;
(
    // clock and control
    input  wire logic             mclk_i,
    input  wire logic             reset_i,
    input  wire logic             ce_i,
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] length_i,
    // status
    output logic                  done_o
);
    import conv_pkg::*;

    logic [CNT_W-1:0] count_reg;

    // ==========================================================
    // down counter, done pulses on the last cycle
    // ==========================================================
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
            count_reg <= CNT_ZERO;
        else if (ce_i)
        begin
            if (load_i)
                count_reg <= length_i;
            else if (count_reg != CNT_ZERO)
                count_reg <= count_reg - CNT_ONE;
        end
    end

    assign done_o = (count_reg == CNT_ONE) && !load_i;

endmodule // conv_timer

// >>> logic/result_coder.sv
`timescale 1ns/1ps

module result_coder
    import conv_pkg::*;
(
    // sample and mode
    input  wire logic [RESULT_W-1:0] sample_i,
    input  wire logic                bipolar_i,
    // coded result
    output logic      [RESULT_W-1:0] code_o
);
    import conv_pkg::*;

    // ==========================================================
    // sample is a two's complement value in bipolar mode
    // ==========================================================
    // flipping msb gives offset binary, so zero lands on 7ff/800 edge
    assign code_o = bipolar_i ? (sample_i ^ SIGN_FLIP) : sample_i;

endmodule // result_coder

// >>> testbench/host_model.sv
`timescale 1ns/1ps

module host_model
(
    // clock and converter status
    input  wire logic mclk_i,
    input  wire logic busy_n_i,
    // control lines towards the converter
    output logic      conversion_start_n_o,
    output logic      chip_select_n_o,
    output logic      read_n_o
);
    // ==========================================================
    // idle: all strobes released high
    // ==========================================================
    initial
    begin
        conversion_start_n_o = 1'b1;
        chip_select_n_o      = 1'b1;
        read_n_o             = 1'b1;
    end

    // caller sits just after a falling edge; lines change there only
    task automatic drive(input logic start_n, input logic cs_n, input logic rd_n);
        begin
            // a fresh start pulse is held back while busy is low
            if (busy_n_i === 1'b1 || start_n === 1'b1)
                conversion_start_n_o = start_n;
            chip_select_n_o = cs_n;
            read_n_o        = rd_n;
        end
    endtask
endmodule // host_model

// >>> testbench/testbench.sv
`timescale 1ns/1ps

module testbench;
    import conv_pkg::*;

    localparam int LEN = 3;

    logic              mclk_i;
    logic              reset_i;
    logic              ce_i;
    logic              bipolar_i;
    logic [11:0]       sample_i;
    logic              conversion_start_n;
    logic              chip_select_n;
    logic              read_n;
    logic              busy_n_o;
    logic              hold_o;
    logic [11:0]       result_bus_o;
    logic              result_bus_oe_o;
    int                fails;
    int                comparisons;

    // ==========================================================
    // design and host
    // ==========================================================
    conv_control #(.CONV_LEN(8'(LEN))) dut
    (
        .mclk_i               (mclk_i),
        .reset_i              (reset_i),
        .ce_i                 (ce_i),
        .conversion_start_n_i (conversion_start_n),
        .bipolar_i            (bipolar_i),
        .sample_i             (sample_i),
        .chip_select_n_i      (chip_select_n),
        .read_n_i             (read_n),
        .busy_n_o             (busy_n_o),
        .hold_o               (hold_o),
        .result_bus_o         (result_bus_o),
        .result_bus_oe_o      (result_bus_oe_o)
    );

    host_model host
    (
        .mclk_i               (mclk_i),
        .busy_n_i             (busy_n_o),
        .conversion_start_n_o (conversion_start_n),
        .chip_select_n_o      (chip_select_n),
        .read_n_o             (read_n)
    );

    // ==========================================================
    // clock and checking helpers
    // ==========================================================
    initial
    begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic chk_bit(input string what, input logic seen, input logic exp);
        begin
            comparisons++;
            if (seen !== exp)
            begin
                fails++;
                $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
            end
        end
    endtask

    task automatic chk_word(input string what, input logic [11:0] seen, input logic [11:0] exp);
        begin
            comparisons++;
            if (seen !== exp)
            begin
                fails++;
                $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task automatic end_of_test;
        begin
            $display("comparisons %0d fails %0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    // one full conversion; rd_low keeps select and read low throughout
    task automatic convert(input logic bip, input logic [11:0] smp, input logic [11:0] code,
                           input logic rd_low);
        int j;
        begin
            bipolar_i = bip;
            sample_i  = smp;
            host.drive(1'b0, ~rd_low, ~rd_low);
            @(negedge mclk_i);
            chk_bit("hold", hold_o, 1'b1);
            chk_bit("busy idle in hold", busy_n_o, 1'b1);
            host.drive(1'b1, ~rd_low, ~rd_low);
            for (j = 1; j <= LEN + 2; j++)
            begin
                @(negedge mclk_i);
                if (j <= LEN + 1)
                    chk_bit("busy", busy_n_o, 1'b0);
                else
                    chk_bit("busy end", busy_n_o, 1'b1);
                if (j <= LEN)
                    chk_bit("oe in conversion", result_bus_oe_o, 1'b0);
                if (j == LEN)
                    chk_bit("hold in conversion", hold_o, 1'b1);
                if (j == LEN + 1)
                    chk_bit("oe before busy", result_bus_oe_o, rd_low);
                if (j == LEN + 1 && rd_low)
                    chk_word("result", result_bus_o, code);
            end
            @(negedge mclk_i);
            chk_bit("track", hold_o, 1'b0);
            chk_bit("oe after", result_bus_oe_o, rd_low);
        end
    endtask

    // read the held result with a select-only step first
    task automatic read_back(input logic [11:0] code);
        begin
            host.drive(1'b1, 1'b0, 1'b1);
            @(negedge mclk_i);
            @(negedge mclk_i);
            chk_bit("oe select only", result_bus_oe_o, 1'b0);
            host.drive(1'b1, 1'b0, 1'b0);
            @(negedge mclk_i);
            chk_bit("oe read", result_bus_oe_o, 1'b1);
            chk_word("read data", result_bus_o, code);
            host.drive(1'b1, 1'b1, 1'b1);
            @(negedge mclk_i);
            @(negedge mclk_i);
            chk_bit("oe released", result_bus_oe_o, 1'b0);
        end
    endtask

    // enable dropped mid-conversion stretches it by the frozen cycles
    task automatic freeze_conv();
        begin
            host.drive(1'b0, 1'b1, 1'b1);
            @(negedge mclk_i);
            host.drive(1'b1, 1'b1, 1'b1);
            @(negedge mclk_i);
            ce_i = 1'b0;
            repeat (LEN + 2) @(negedge mclk_i);
            chk_bit("busy frozen", busy_n_o, 1'b0);
            chk_bit("hold frozen", hold_o, 1'b1);
            ce_i = 1'b1;
            repeat (LEN) @(negedge mclk_i);
            chk_bit("busy before thaw end", busy_n_o, 1'b0);
            @(negedge mclk_i);
            chk_bit("busy after thaw", busy_n_o, 1'b1);
        end
    endtask

    // reset in mid-conversion abandons it and leaves the block idle
    task automatic reset_in_conv();
        begin
            host.drive(1'b0, 1'b0, 1'b0);
            @(negedge mclk_i);
            host.drive(1'b1, 1'b0, 1'b0);
            @(negedge mclk_i);
            chk_bit("busy before reset", busy_n_o, 1'b0);
            reset_i = 1'b1;
            repeat (2) @(negedge mclk_i);
            reset_i = 1'b0;
            chk_bit("busy in reset", busy_n_o, 1'b1);
            chk_bit("hold in reset", hold_o, 1'b0);
            chk_bit("oe in reset", result_bus_oe_o, 1'b0);
            @(negedge mclk_i);
            chk_bit("oe after reset", result_bus_oe_o, 1'b1);
            chk_word("bus after reset", result_bus_o, CODE_ZERO);
            host.drive(1'b1, 1'b1, 1'b1);
            @(negedge mclk_i);
        end
    endtask

    // ==========================================================
    // main sequence and watchdog
    // ==========================================================
    initial
    begin
        #20000;
        fails++;
        end_of_test();
    end

    initial
    begin
        fails       = 0;
        comparisons = 0;
        reset_i     = 1'b1;
        ce_i        = 1'b1;
        bipolar_i   = 1'b0;
        sample_i    = 12'h000;
        repeat (10) @(negedge mclk_i);
        reset_i = 1'b0;
        @(negedge mclk_i);
        chk_bit("reset busy", busy_n_o, 1'b1);
        chk_bit("reset hold", hold_o, 1'b0);
        chk_bit("reset oe", result_bus_oe_o, 1'b0);
        convert(1'b1, 12'h000, CODE_MID_HIGH, 1'b1);
        convert(1'b1, 12'hfff, CODE_MID_LOW, 1'b1);
        convert(1'b1, 12'h800, CODE_ZERO, 1'b1);
        convert(1'b0, 12'hffe, 12'hffe, 1'b1);
        convert(1'b0, 12'h001, 12'h001, 1'b1);
        convert(1'b1, 12'h7ff, CODE_TOP, 1'b0);
        read_back(CODE_TOP);
        freeze_conv();
        reset_in_conv();
        convert(1'b0, 12'ha53, 12'ha53, 1'b0);
        read_back(12'ha53);
        end_of_test();
    end
endmodule // testbench
